// file: rtl/rph_defines.vh
// constants of the receive packet handler
// Behaviour
// - fixed length when style 0, count nonzero
// - payload 255 max, message 64 decrypting
// - variable length when style 1, first byte
// - length excludes itself, frame at least 2
// - unlimited when style 0, count zero
// - unlimited mode: no check, no ready event
// - pattern detect off: no id filtering
// - only payload bytes enter the queue
// - length above maximum discards the frame
// - id byte first fixed, second variable
// - filter 01 own id, 10 own or group
// - id byte stays in the queue
// - pattern starts reception, sets match flag
// - check fail clears queue unless keep bit
// - ccitt checksum compared, result stored, stripped
// - frame ready on event pin 0
// - 128-bit key write only, retained
// - decrypt buffered frame, ready after decrypt
// - 7.0 us per block before ready
// - decrypt payload at most 64 message bytes
`ifndef RPH_DEFINES_VH
`define RPH_DEFINES_VH

// =====================================================
// queue
`define RPH_FIFO_DEPTH 7'h42
`define RPH_FIFO_LAST 7'h41
`define RPH_PTR_W 7

// =====================================================
// framing
`define RPH_FMT_FIXED 1'b0
`define RPH_FMT_VAR 1'b1
`define RPH_FILT_OFF 2'b00
`define RPH_FILT_NODE 2'b01
`define RPH_FILT_GROUP 2'b10
`define RPH_MAX_MSG_AES 9'h040
`define RPH_KEY_BYTES 16

// =====================================================
// checksum
`define RPH_CRC_POLY 16'h1021
`define RPH_CRC_PRESET 16'h1D0F
`define RPH_CRC_XOROUT 16'hFFFF

// =====================================================
// timing
`define RPH_CLK_PERIOD_NS 20
`define RPH_AES_BLOCK_NS 7000

`endif

// file: rtl/rph_crc16.v
// byte-serial ccitt checksum engine
`timescale 1ns/10ps
`include "rph_defines.vh"
module rph_crc16
(
    // clock and reset
    input wire clk_sys_in,
    input wire arst_n_in,
    // control
    input wire init_in,
    input wire en_in,
    input wire [7:0] data_in,
    // result
    output reg [15:0] crc_out
);

function [15:0] crc_byte;
    input [15:0] c;
    input [7:0] d;
    integer i;
    reg [15:0] r;
    begin
        r = c;
        for (i = 7; i >= 0; i = i - 1)
        begin
            // msb first; the nonzero preset makes leading zeros visible
            if (r[15] ^ d[i])
                r = {r[14:0], 1'b0} ^ `RPH_CRC_POLY;
            else
                r = {r[14:0], 1'b0};
        end
        crc_byte = r;
    end
endfunction

always @(posedge clk_sys_in or negedge arst_n_in)
begin
    if (!arst_n_in)
        crc_out <= `RPH_CRC_PRESET;
    else if (init_in)
        crc_out <= `RPH_CRC_PRESET;
    else if (en_in)
        crc_out <= crc_byte(crc_out, data_in);
end

endmodule // rph_crc16

// file: rtl/rph_rx_packet_handler.v
// receive packet handler: framing, filtering, checksum, queue, decrypt pass
`timescale 1ns/10ps
`include "rph_defines.vh"
module rph_rx_packet_handler
(
    // clock and reset
    input wire clk_sys_in,
    input wire arst_n_in,
    // receive stream after pattern detection
    input wire rx_on_in,
    input wire sync_found_in,
    input wire rx_byte_valid_in,
    input wire [7:0] rx_byte_in,
    // configuration
    input wire frame_length_style_in,
    input wire [7:0] max_payload_count_in,
    input wire pattern_detect_on_in,
    input wire check_on_in,
    input wire keep_on_check_fail_in,
    input wire [1:0] id_filter_select_in,
    input wire [7:0] own_node_id_in,
    input wire [7:0] group_node_id_in,
    input wire decrypt_on_in,
    input wire [6:0] queue_threshold_in,
    // key write port
    input wire key_wr_in,
    input wire [3:0] key_idx_in,
    input wire [7:0] key_data_in,
    // queue read port
    input wire fifo_rd_in,
    output reg [7:0] fifo_data_out,
    // status and events
    output reg queue_has_data_out,
    output reg queue_level_hit_out,
    output reg pattern_id_match_out,
    output reg check_passed_out,
    output reg event_pin_0_out
);

// =====================================================
// states and derived timing
localparam ST_IDLE = 3'h0;
localparam ST_PAYLOAD = 3'h1;
localparam ST_CRC_HI = 3'h2;
localparam ST_CRC_LO = 3'h3;
localparam ST_DECRYPT = 3'h4;
localparam integer AES_BLOCK_CYC =
    (`RPH_AES_BLOCK_NS + `RPH_CLK_PERIOD_NS - 1) / `RPH_CLK_PERIOD_NS;
localparam [10:0] AES_BLOCK_CYC11 = AES_BLOCK_CYC[10:0];

// =====================================================
// storage
reg [7:0] mem [0:`RPH_FIFO_DEPTH-1];
reg [7:0] key_mem [0:`RPH_KEY_BYTES-1];
reg [2:0] state_q;
reg rx_on_q;
reg [6:0] wr_ptr_q;
reg [6:0] rd_ptr_q;
reg [6:0] count_q;
reg [6:0] frame_base_q;
reg [7:0] byte_idx_q;
reg [8:0] total_q;
reg unlimited_q;
reg var_q;
reg addr_en_q;
reg [7:0] crc_hi_q;
reg [6:0] dec_ptr_q;
reg [8:0] dec_pos_q;
reg [10:0] dec_cyc_q;

// =====================================================
// combinational decode
wire rx_rise = rx_on_in & ~rx_on_q;
wire [1:0] hdr_len = {1'b0, var_q} + {1'b0, addr_en_q};
wire addr_en_now = pattern_detect_on_in & (id_filter_select_in != `RPH_FILT_OFF);
wire unlimited_now = (frame_length_style_in == `RPH_FMT_FIXED) &
    (max_payload_count_in == 8'h00);
wire fixed_too_long = decrypt_on_in & ~unlimited_now &
    (frame_length_style_in == `RPH_FMT_FIXED) &
    ({1'b0, max_payload_count_in} > (`RPH_MAX_MSG_AES + {8'h00, addr_en_now}));
wire start_frame = (state_q == ST_IDLE) & rx_on_in & ~fixed_too_long &
    (pattern_detect_on_in ? sync_found_in : rx_rise);
wire pay_byte = (state_q == ST_PAYLOAD) & rx_byte_valid_in;
wire is_len_byte = var_q & (byte_idx_q == 8'h00);
wire len_bad = is_len_byte & ((rx_byte_in == 8'h00) |
    (rx_byte_in > max_payload_count_in) |
    (decrypt_on_in & ({1'b0, rx_byte_in} > (`RPH_MAX_MSG_AES + {8'h00, addr_en_q}))));
wire is_addr_byte = addr_en_q & (byte_idx_q == {7'h00, var_q});
wire addr_ok = (rx_byte_in == own_node_id_in) |
    ((id_filter_select_in == `RPH_FILT_GROUP) & (rx_byte_in == group_node_id_in));
wire addr_bad = is_addr_byte & ~addr_ok;
wire discard = pay_byte & (len_bad | addr_bad);
wire [8:0] pos_next = {1'b0, byte_idx_q} + 9'h001;
wire last_byte = pay_byte & ~discard & ~unlimited_q & ~is_len_byte &
    (pos_next == total_q);
wire [15:0] crc_val;
wire crc_ok = ({crc_hi_q, rx_byte_in} == (crc_val ^ `RPH_CRC_XOROUT));
wire crc_done = (state_q == ST_CRC_LO) & rx_byte_valid_in;
wire crc_fail_clear = crc_done & ~crc_ok & ~keep_on_check_fail_in;
wire finish = (last_byte & ~check_on_in) | (crc_done & ~crc_fail_clear);
wire [8:0] msg_len = total_q - {7'h00, hdr_len};
wire [2:0] blocks = msg_len[6:4] + {2'b00, (msg_len[3:0] != 4'h0)};
wire dec_xor = (state_q == ST_DECRYPT) & (dec_pos_q < total_q) &
    (dec_pos_q >= {7'h00, hdr_len});
wire [8:0] key_pos = dec_pos_q - {7'h00, hdr_len};
wire dec_done = (state_q == ST_DECRYPT) & (dec_cyc_q == 11'h001);
wire flush = rx_rise | discard | crc_fail_clear;
// payload only: pattern and checksum bytes never reach the queue
wire push = pay_byte & ~discard & (count_q != `RPH_FIFO_DEPTH);
// reads wait while decryption rewrites the buffer in place
wire pop = fifo_rd_in & (count_q != 7'h00) & (state_q != ST_DECRYPT);
reg [6:0] count_d;

function [6:0] ptr_inc;
    input [6:0] p;
    begin
        ptr_inc = (p == `RPH_FIFO_LAST) ? 7'h00 : p + 7'h01;
    end
endfunction

always @*
begin
    count_d = count_q;
    if (flush)
        count_d = 7'h00;
    else if (push & ~pop)
        count_d = count_q + 7'h01;
    else if (pop & ~push)
        count_d = count_q - 7'h01;
end

// =====================================================
// checksum engine
rph_crc16 u_crc
(
    .clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in),
    .init_in(start_frame),
    .en_in(pay_byte & ~discard),
    .data_in(rx_byte_in),
    .crc_out(crc_val)
);

// =====================================================
// memories: no reset, the key survives sleep with the logic powered
always @(posedge clk_sys_in)
begin
    if (push)
        mem[wr_ptr_q] <= rx_byte_in;
    else if (dec_xor)
        mem[dec_ptr_q] <= mem[dec_ptr_q] ^ key_mem[key_pos[3:0]];
    if (key_wr_in)
        key_mem[key_idx_in] <= key_data_in;
end

// =====================================================
// queue pointers and read data
always @(posedge clk_sys_in or negedge arst_n_in)
begin
    if (!arst_n_in)
    begin
        wr_ptr_q <= 7'h00;
        rd_ptr_q <= 7'h00;
        count_q <= 7'h00;
        fifo_data_out <= 8'h00;
        queue_has_data_out <= 1'b0;
        queue_level_hit_out <= 1'b0;
    end
    else
    begin
        count_q <= count_d;
        queue_has_data_out <= (count_d != 7'h00);
        queue_level_hit_out <= (count_d > queue_threshold_in);
        if (pop)
            fifo_data_out <= mem[rd_ptr_q];
        if (flush)
        begin
            wr_ptr_q <= 7'h00;
            rd_ptr_q <= 7'h00;
        end
        else
        begin
            if (push)
                wr_ptr_q <= ptr_inc(wr_ptr_q);
            if (pop)
                rd_ptr_q <= ptr_inc(rd_ptr_q);
        end
    end
end

// =====================================================
// frame sequencer
always @(posedge clk_sys_in or negedge arst_n_in)
begin
    if (!arst_n_in)
    begin
        state_q <= ST_IDLE;
        rx_on_q <= 1'b0;
        frame_base_q <= 7'h00;
        byte_idx_q <= 8'h00;
        total_q <= 9'h000;
        unlimited_q <= 1'b0;
        var_q <= 1'b0;
        addr_en_q <= 1'b0;
        crc_hi_q <= 8'h00;
        dec_ptr_q <= 7'h00;
        dec_pos_q <= 9'h000;
        dec_cyc_q <= 11'h000;
    end
    else
    begin
        rx_on_q <= rx_on_in;
        case (state_q)
            ST_IDLE:
            begin
                if (start_frame)
                begin
                    state_q <= ST_PAYLOAD;
                    frame_base_q <= rx_rise ? 7'h00 : wr_ptr_q;
                    byte_idx_q <= 8'h00;
                    unlimited_q <= unlimited_now;
                    var_q <= frame_length_style_in;
                    addr_en_q <= addr_en_now;
                    total_q <= {1'b0, max_payload_count_in};
                end
            end
            ST_PAYLOAD:
            begin
                if (!rx_on_in || discard)
                    state_q <= ST_IDLE;
                else if (pay_byte)
                begin
                    // unlimited frames never count against the maximum
                    if (!unlimited_q)
                        byte_idx_q <= pos_next[7:0];
                    if (is_len_byte)
                        total_q <= {1'b0, rx_byte_in} + 9'h001;
                    if (last_byte)
                    begin
                        if (check_on_in)
                            state_q <= ST_CRC_HI;
                        else if (decrypt_on_in)
                            state_q <= ST_DECRYPT;
                        else
                            state_q <= ST_IDLE;
                    end
                end
                if (last_byte)
                begin
                    dec_ptr_q <= frame_base_q;
                    dec_pos_q <= 9'h000;
                end
            end
            ST_CRC_HI:
            begin
                if (!rx_on_in)
                    state_q <= ST_IDLE;
                else if (rx_byte_valid_in)
                begin
                    crc_hi_q <= rx_byte_in;
                    state_q <= ST_CRC_LO;
                end
            end
            ST_CRC_LO:
            begin
                if (!rx_on_in)
                    state_q <= ST_IDLE;
                else if (crc_done)
                    state_q <= (finish & decrypt_on_in) ? ST_DECRYPT : ST_IDLE;
            end
            ST_DECRYPT:
            begin
                // block timing models the cipher latency before ready
                if (dec_cyc_q == 11'h000)
                    dec_cyc_q <= blocks * AES_BLOCK_CYC11;
                else if (dec_done)
                begin
                    dec_cyc_q <= 11'h000;
                    state_q <= ST_IDLE;
                end
                else
                    dec_cyc_q <= dec_cyc_q - 11'h001;
                if (dec_pos_q < total_q)
                begin
                    dec_pos_q <= dec_pos_q + 9'h001;
                    dec_ptr_q <= ptr_inc(dec_ptr_q);
                end
            end
            default:
                state_q <= ST_IDLE;
        endcase
    end
end

// =====================================================
// status flags: a set in the same cycle as a clear wins
always @(posedge clk_sys_in or negedge arst_n_in)
begin
    if (!arst_n_in)
    begin
        pattern_id_match_out <= 1'b0;
        check_passed_out <= 1'b0;
        event_pin_0_out <= 1'b0;
    end
    else
    begin
        if (start_frame && pattern_detect_on_in)
            pattern_id_match_out <= 1'b1;
        else if (!rx_on_in || addr_bad || (count_q != 7'h00 && count_d == 7'h00))
            pattern_id_match_out <= 1'b0;

        if (crc_done)
            check_passed_out <= crc_ok;
        else if (start_frame)
            check_passed_out <= 1'b0;

        // unlimited frames never reach finish, so never raise ready
        if ((finish && !decrypt_on_in) || dec_done)
            event_pin_0_out <= 1'b1;
        else if (rx_rise || start_frame || (count_q != 7'h00 && count_d == 7'h00))
            event_pin_0_out <= 1'b0;
    end
end

endmodule // rph_rx_packet_handler

// file: verif/rph_rx_packet_handler_assertions.sv
// port assertions for the receive packet handler
`timescale 1ns/10ps
module rph_rx_checker
(
    // clock and reset
    input wire clk_sys_in,
    input wire arst_n_in,
    // inputs watched
    input wire rx_on_in,
    input wire sync_found_in,
    input wire frame_length_style_in,
    input wire [7:0] max_payload_count_in,
    input wire pattern_detect_on_in,
    input wire check_on_in,
    input wire keep_on_check_fail_in,
    input wire decrypt_on_in,
    // outputs watched
    input wire queue_has_data_out,
    input wire queue_level_hit_out,
    input wire pattern_id_match_out,
    input wire check_passed_out,
    input wire event_pin_0_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!arst_n_in);
    // ========
    // assertions
    a_sync_sets_match: assert property (
        sync_found_in && rx_on_in && pattern_detect_on_in |=> pattern_id_match_out)
        else $error("match flag missing after pattern");
    a_rx_off_clears: assert property (
        !rx_on_in |=> !pattern_id_match_out) else $error("match flag kept outside rx");
    a_start_clears_pass: assert property (
        sync_found_in && rx_on_in && pattern_detect_on_in |=> !check_passed_out)
        else $error("check flag kept at frame start");
    a_level_has_data: assert property (
        queue_level_hit_out |-> queue_has_data_out) else $error("level flag on empty queue");
    a_ready_has_data: assert property (
        $rose(event_pin_0_out) |-> queue_has_data_out) else $error("ready with empty queue");
    a_unlim_no_ready: assert property (
        $rose(event_pin_0_out) |-> frame_length_style_in || max_payload_count_in != 8'h00)
        else $error("ready raised in unlimited mode");
    a_pass_needs_check: assert property (
        $rose(check_passed_out) |-> check_on_in) else $error("check flag without checking");
    a_fail_no_ready: assert property (
        $rose(event_pin_0_out) && check_on_in && !keep_on_check_fail_in |-> check_passed_out)
        else $error("ready after failed check");
    a_decrypt_delay: assert property (
        $rose(check_passed_out) && decrypt_on_in |-> !event_pin_0_out [*8])
        else $error("ready too soon after check");
    cover property ($rose(event_pin_0_out));
    cover property ($fell(pattern_id_match_out) && rx_on_in);
    cover property ($rose(queue_level_hit_out));
endmodule // rph_rx_checker

bind rph_rx_packet_handler rph_rx_checker u_chk
(
    .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .rx_on_in(rx_on_in),
    .sync_found_in(sync_found_in), .frame_length_style_in(frame_length_style_in),
    .max_payload_count_in(max_payload_count_in), .pattern_detect_on_in(pattern_detect_on_in),
    .check_on_in(check_on_in), .keep_on_check_fail_in(keep_on_check_fail_in),
    .decrypt_on_in(decrypt_on_in), .queue_has_data_out(queue_has_data_out),
    .queue_level_hit_out(queue_level_hit_out), .pattern_id_match_out(pattern_id_match_out),
    .check_passed_out(check_passed_out), .event_pin_0_out(event_pin_0_out)
);

// file: verif/rph_host_model.sv
// host model: pops the queue while allowed, with stalls
`timescale 1ns/10ps
module rph_host_model
(
    // clock and reset
    input wire clk_sys_in,
    input wire arst_n_in,
    // control from the bench
    input wire read_en_in,
    input wire stall_in,
    // queue side
    input wire queue_has_data_in,
    input wire [7:0] fifo_data_in,
    output reg fifo_rd_out,
    // bytes collected
    output reg got_valid_out,
    output wire [7:0] got_byte_out
);
    assign got_byte_out = fifo_data_in;
    // one idle cycle after each pop so the not-empty flag is fresh before the next
    always @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            fifo_rd_out <= 1'h0;
            got_valid_out <= 1'h0;
        end
        else
        begin
            got_valid_out <= fifo_rd_out & queue_has_data_in;
            fifo_rd_out <= read_en_in & queue_has_data_in & ~fifo_rd_out & ~stall_in;
        end
    end
endmodule // rph_host_model

// file: verif/rph_rx_packet_handler_tb_top.sv
// self-checking bench for the receive packet handler
`timescale 1ns/10ps
`include "rph_defines.vh"
module rph_rx_packet_handler_tb_top;
    reg clk_sys_in, arst_n_in, rx_on, sync, vld, style, chk, keep, dec, kwr, en, stall, pat;
    reg [7:0] rxb, maxc, kdat;
    reg [1:0] filt;
    reg [3:0] kidx;
    reg [31:0] seed;
    reg [7:0] pl [0:79];
    integer err_count, check_count, i, k, n;
    wire rd, gv, has, lvl, mat, pass, evt;
    wire [7:0] dout, gb;
    localparam [7:0] own_id = 8'hA5;
    localparam [7:0] grp_id = 8'h3C;
    localparam [7:0] key_byte = 8'hC3;

    rph_rx_packet_handler u_dut
    (
        .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .rx_on_in(rx_on), .sync_found_in(sync),
        .rx_byte_valid_in(vld), .rx_byte_in(rxb), .frame_length_style_in(style),
        .max_payload_count_in(maxc), .pattern_detect_on_in(pat), .check_on_in(chk),
        .keep_on_check_fail_in(keep), .id_filter_select_in(filt), .own_node_id_in(own_id),
        .group_node_id_in(grp_id), .decrypt_on_in(dec), .queue_threshold_in(7'h03),
        .key_wr_in(kwr), .key_idx_in(kidx), .key_data_in(kdat), .fifo_rd_in(rd),
        .fifo_data_out(dout), .queue_has_data_out(has), .queue_level_hit_out(lvl),
        .pattern_id_match_out(mat), .check_passed_out(pass), .event_pin_0_out(evt)
    );
    rph_host_model u_host
    (
        .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .read_en_in(en), .stall_in(stall),
        .queue_has_data_in(has), .fifo_data_in(dout), .fifo_rd_out(rd), .got_valid_out(gv),
        .got_byte_out(gb)
    );

    initial
    begin
        clk_sys_in = 1'h0;
        forever #10 clk_sys_in = ~clk_sys_in;
    end

    // ========
    // helpers
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction

    function [15:0] crc(input integer len);
        integer j, b;
        reg [15:0] c;
        begin
            c = `RPH_CRC_PRESET;
            for (j = 0; j < len; j = j + 1)
                for (b = 7; b >= 0; b = b - 1)
                    c = (c << 1) ^ ((c[15] ^ pl[j][b]) ? `RPH_CRC_POLY : 16'h0000);
            crc = c ^ `RPH_CRC_XOROUT;
        end
    endfunction

    task cmp(input [31:0] seen, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp)
            begin
                err_count = err_count + 1;
                $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask

    task summarize;
        begin
            if (err_count == 0 && check_count > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask

    task put(input [7:0] b);
        begin
            vld <= 1'h1;
            rxb <= b;
            @(posedge clk_sys_in);
            vld <= 1'h0;
            @(posedge clk_sys_in);
        end
    endtask

    task mk(input [7:0] b0, input [7:0] b1, input integer len);
        begin
            n = len;
            for (i = 0; i < len; i = i + 1)
            begin
                seed = xs(seed);
                pl[i] = (i == 0) ? b0 : (i == 1) ? b1 : seed[7:0];
            end
        end
    endtask

    // one frame from rx start to drained queue; bad corrupts the checksum
    task frame(input v, input [7:0] m, input [1:0] f, input c, input kp, input d, input bad,
        input ok, input pk, input integer nb);
        reg [15:0] r;
        integer w, q;
        begin
            rx_on <= 1'h0;
            style <= v;
            maxc <= m;
            filt <= f;
            chk <= c;
            keep <= kp;
            dec <= d;
            en <= 1'h0;
            @(posedge clk_sys_in);
            rx_on <= 1'h1;
            @(posedge clk_sys_in);
            sync <= 1'h1;
            @(posedge clk_sys_in);
            sync <= 1'h0;
            @(posedge clk_sys_in);
            cmp(mat, pat);
            for (i = 0; i < n; i = i + 1)
                put(pl[i]);
            r = crc(n) ^ {15'h0000, bad};
            if (c && (v || m != 8'h00))
            begin
                put(r[15:8]);
                put(r[7:0]);
            end
            w = 0;
            while (evt !== 1'h1 && w < (ok ? 800 : 30))
            begin
                @(posedge clk_sys_in);
                w = w + 1;
            end
            if (ok)
                cmp(w > 300, d);
            cmp(evt, ok);
            cmp(pass, pk);
            cmp({has, lvl}, {nb != 0, nb > 3});
            if (ok && w == 800)
            begin
                err_count = err_count + 1;
                summarize;
            end
            en <= 1'h1;
            q = 0;
            w = 0;
            // host stalls at random while draining, so pops are not evenly spaced
            while ((has === 1'h1 || gv === 1'h1) && w < 400)
            begin
                stall <= seed[9];
                seed = xs(seed);
                @(posedge clk_sys_in);
                w = w + 1;
                if (gv === 1'h1)
                begin
                    cmp(gb, (d && q > 0) ? pl[q] ^ key_byte : pl[q]);
                    q = q + 1;
                end
            end
            cmp(q, nb);
            if (w == 400)
            begin
                err_count = err_count + 1;
                summarize;
            end
        end
    endtask

    // ========
    // main sequence
    initial
    begin
        arst_n_in = 1'h0;
        {rx_on, sync, vld, style, chk, keep, dec, kwr, en, stall} = 10'h000;
        {rxb, maxc, kdat, filt, kidx} = 30'h00000000;
        seed = 32'h66EB;
        pat = 1'h1;
        err_count = 0;
        check_count = 0;
        repeat (3) @(posedge clk_sys_in);
        arst_n_in <= 1'h1;
        @(posedge clk_sys_in);
        cmp({evt, pass, has, mat, lvl}, 5'h00);
        for (k = 0; k < 16; k = k + 1)
        begin
            kwr <= 1'h1;
            kidx <= k[3:0];
            kdat <= key_byte;
            @(posedge clk_sys_in);
        end
        kwr <= 1'h0;
        for (k = 0; k < 6; k = k + 1)
        begin
            seed = xs(seed);
            n = 2 + seed[5:0] % 60;
            if (k[0])
            begin
                mk(n - 1, grp_id, n);
                frame(1, (k == 3) ? 8'hFF : n - 1, 2, 1, 0, 0, 0, 1, 1, n);
            end
            else
            begin
                mk(own_id, 8'h77, n);
                frame(0, n, 1, 1, 0, 0, 0, 1, 1, n);
            end
        end
        mk(8'h09, own_id, 10);
        frame(1, 8'h08, 1, 1, 0, 0, 0, 0, 0, 0);
        mk(grp_id, 8'h77, 5);
        frame(0, 8'h05, 1, 1, 0, 0, 0, 0, 0, 0);
        cmp(mat, 1'h0);
        mk(own_id, 8'h77, 6);
        frame(0, 8'h06, 1, 1, 0, 0, 1, 0, 0, 0);
        frame(0, 8'h06, 1, 1, 1, 0, 1, 1, 0, 6);
        frame(0, 8'h00, 0, 1, 0, 0, 0, 0, 0, 6);
        // reset mid-run: the key store has no reset and must survive it
        arst_n_in <= 1'h0;
        repeat (2) @(posedge clk_sys_in);
        arst_n_in <= 1'h1;
        @(posedge clk_sys_in);
        cmp({evt, pass, has, mat, lvl}, 5'h00);
        mk(own_id, 8'h77, 17);
        frame(0, 8'h11, 1, 1, 0, 1, 0, 1, 1, 17);
        // pattern detect off: a foreign id byte must pass unfiltered
        pat <= 1'h0;
        mk(grp_id, 8'h77, 5);
        frame(0, 8'h05, 1, 1, 0, 0, 0, 1, 1, 5);
        summarize;
    end
endmodule // rph_rx_packet_handler_tb_top
